// ---- hw/adc_serial_control_sequencer.sv ----
`timescale 1ns/1ns
module adc_serial_control_sequencer #(
  parameter int STEP_CYC = adc_seq_pkg::INT_STEP_CYC,
  parameter bit HAS_INT_REF = 1'b1
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic comparator_high,
  output logic dout_o,
  output logic dout_oe_n,
  output logic strobe_o,
  output logic strobe_oe_n,
  output logic [9:0] dac_code,
  output adc_seq_pkg::route_type route,
  output logic [9:0] result_data_q,
  output logic result_valid_q,
  output logic result_unipolar_q,
  output logic power_down_full_q,
  output logic power_down_fast_q
);
  logic rst_meta_q, rst_n_q, link_rst_n;
  adc_seq_pkg::ctrl_type link_cfg, cfg_q, cfg_d;
  logic [2:0] link_chan, pos_idx;
  logic link_cfg_tgl, link_done_tgl, link_conv, link_track, link_strobe, link_dout;
  logic [9:0] link_result, link_trial;
  logic [1:0] tgl_meta_q, tgl_mid_q, tgl_late_q, tgl_seen_q, tgl_seen_d, evt;
  logic cfg_evt, done_evt, int_mode, single;
  adc_seq_pkg::int_state_type state_q, state_d;
  logic [11:0] cnt_q, cnt_d;
  logic [3:0] idx_q, idx_d;
  logic [9:0] sar_q, sar_d, trial_q, trial_d, result_d, int_result_q, int_result_d;
  logic valid_d, unipolar_d, pd_full_d, pd_fast_d;
  logic [1:0] new_mode;

  // Reset release through two flops; the link frame state also drops out whenever chip select is high
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end
  assign link_rst_n = rst_n_q & ~cs_n;

  serial_link_engine link (
    .sclk(sclk),
    .link_rst_n(link_rst_n),
    .sync_rst_n(rst_n_q),
    .sdi(sdi),
    .comp_hi(comparator_high),
    .int_ready(state_q == adc_seq_pkg::INT_READY),
    .int_result(int_result_q),
    .cfg_q(link_cfg),
    .chan_q(link_chan),
    .cfg_tgl_q(link_cfg_tgl),
    .done_tgl_q(link_done_tgl),
    .res_q(link_result),
    .trial_q(link_trial),
    .converting_q(link_conv),
    .tracking_q(link_track),
    .strobe_q(link_strobe),
    .dout_q(link_dout)
  );

  // Toggle events from the serial domain; the words they announce stay put for many serial clocks
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tgl_meta_q <= 2'h0;
      tgl_mid_q <= 2'h0;
      tgl_late_q <= 2'h0;
      tgl_seen_q <= 2'h0;
    end else begin
      tgl_meta_q <= {link_done_tgl, link_cfg_tgl};
      tgl_mid_q <= tgl_meta_q;
      tgl_late_q <= tgl_mid_q;
      tgl_seen_q <= tgl_seen_d;
    end
  end
  assign evt = ~(tgl_mid_q ^ tgl_late_q) & (tgl_late_q ^ tgl_seen_q);
  assign tgl_seen_d = tgl_seen_q ^ evt;
  assign cfg_evt = evt[0];
  assign done_evt = evt[1];
  assign new_mode = {link_cfg.mode_bit_high, link_cfg.mode_bit_low};

  // Mode decode and the internal-clock converter paced from the reference clock
  always_comb begin
    cfg_d = cfg_q;
    state_d = state_q;
    cnt_d = cnt_q;
    idx_d = idx_q;
    sar_d = sar_q;
    trial_d = trial_q;
    result_d = result_data_q;
    int_result_d = int_result_q;
    valid_d = 1'b0;
    unipolar_d = result_unipolar_q;
    pd_full_d = power_down_full_q;
    pd_fast_d = power_down_fast_q;
    if (cfg_evt) begin
      cfg_d = link_cfg;
      pd_full_d = new_mode == adc_seq_pkg::MODE_FULL_PD || (!HAS_INT_REF && new_mode == adc_seq_pkg::MODE_FAST_PD);
      pd_fast_d = HAS_INT_REF && new_mode == adc_seq_pkg::MODE_FAST_PD; // see [R16]
      state_d = adc_seq_pkg::INT_IDLE;
      if (new_mode == adc_seq_pkg::MODE_INT) begin // see [R16]
        state_d = adc_seq_pkg::INT_CONV;
        cnt_d = 12'h000;
        idx_d = 4'h0;
        sar_d = adc_seq_pkg::RESULT_RESET;
        trial_d = adc_seq_pkg::SAR_MSB;
      end
    end else begin
      unique case (state_q)
        adc_seq_pkg::INT_IDLE, adc_seq_pkg::INT_READY: begin
        end
        adc_seq_pkg::INT_CONV: begin
          cnt_d = cnt_q + 12'h001;
          if (cnt_q == 12'(STEP_CYC - 1)) begin
            cnt_d = 12'h000;
            idx_d = idx_q + 4'h1;
            sar_d = sar_q | (comparator_high ? (adc_seq_pkg::SAR_MSB >> idx_q) : 10'h000);
            trial_d = sar_d | (adc_seq_pkg::SAR_MSB >> (idx_q + 4'h1));
            if (idx_q == adc_seq_pkg::LSB_STEP) begin
              state_d = adc_seq_pkg::INT_READY;
              int_result_d = sar_d; // see [R8]
              result_d = sar_d;
              valid_d = 1'b1;
              unipolar_d = cfg_q.polarity_select;
              trial_d = adc_seq_pkg::RESULT_RESET;
            end
          end
        end
        default: begin
          state_d = adc_seq_pkg::INT_IDLE;
        end
      endcase
    end
    if (done_evt) begin
      result_d = link_result; // see [R20]
      valid_d = 1'b1;
      unipolar_d = cfg_d.polarity_select; // see [R17]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cfg_q <= adc_seq_pkg::CTRL_RESET;
      state_q <= adc_seq_pkg::INT_IDLE;
      cnt_q <= 12'h000;
      idx_q <= 4'h0;
      sar_q <= adc_seq_pkg::RESULT_RESET;
      trial_q <= adc_seq_pkg::RESULT_RESET;
      int_result_q <= adc_seq_pkg::RESULT_RESET;
      result_data_q <= adc_seq_pkg::RESULT_RESET;
      result_valid_q <= 1'b0;
      result_unipolar_q <= 1'b0;
      power_down_full_q <= 1'b0;
      power_down_fast_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      sar_q <= sar_d;
      trial_q <= trial_d;
      int_result_q <= int_result_d;
      result_data_q <= result_d;
      result_valid_q <= valid_d;
      result_unipolar_q <= unipolar_d;
      power_down_full_q <= pd_full_d;
      power_down_fast_q <= pd_fast_d;
    end
  end

  // Pins: internal mode keeps the strobe driven even with chip select high
  assign int_mode = {cfg_q.mode_bit_high, cfg_q.mode_bit_low} == adc_seq_pkg::MODE_INT;
  assign strobe_o = int_mode ? (state_q != adc_seq_pkg::INT_CONV) : link_strobe; // see [R13]
  assign strobe_oe_n = int_mode ? 1'b0 : cs_n;
  assign dout_o = link_dout; // see [R13]
  assign dout_oe_n = cs_n;
  assign dac_code = (state_q == adc_seq_pkg::INT_CONV) ? trial_q : link_trial;

  // Analog routing; input number is {mid, lsb, msb}, the msb select swaps a differential pair
  assign pos_idx = {link_chan[1], link_chan[0], link_chan[2]}; // see [R15]
  assign single = link_cfg.input_config_select; // see [R17]
  always_comb begin
    route.pos_channel = 8'h01 << pos_idx; // see [R1] [R2]
    route.neg_channel = single ? 8'h00 : (8'h01 << (pos_idx ^ 3'h1)); // see [R2]
    route.neg_to_common = single; // see [R1]
    route.hold_capacitor_to_neg = link_conv | (state_q == adc_seq_pkg::INT_CONV); // see [R6] [R7]
    route.track_en = link_track;
  end

  chk_single_common: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // see [R1]
    route.neg_to_common |-> route.neg_channel == 8'h00 && $onehot(route.pos_channel))
    else $error("single-ended route wrong");
  chk_diff_pair: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // see [R2]
    !route.neg_to_common |-> route.neg_channel == {route.pos_channel[6], route.pos_channel[7],
      route.pos_channel[4], route.pos_channel[5], route.pos_channel[2], route.pos_channel[3],
      route.pos_channel[0], route.pos_channel[1]}) else $error("differential pair wrong");
  chk_int_start: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // see [R16]
    (cfg_evt && new_mode == adc_seq_pkg::MODE_INT) |=> state_q == adc_seq_pkg::INT_CONV && strobe_o == 1'b0)
    else $error("internal conversion not started");
  chk_int_finish: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // see [R8]
    (state_q == adc_seq_pkg::INT_CONV && !cfg_evt && idx_q == adc_seq_pkg::LSB_STEP && cnt_q == 12'(STEP_CYC - 1))
    |=> state_q == adc_seq_pkg::INT_READY && result_valid_q && result_data_q == int_result_q)
    else $error("internal result not delivered");
  chk_ext_result: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // see [R20]
    done_evt |=> result_valid_q && result_data_q == $past(link_result)) else $error("external result lost");

  // Mode decode and result hand-over on the reference side
  chk_full_pd: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // see [R16]
    cfg_evt |=> power_down_full_q == ($past(new_mode) == adc_seq_pkg::MODE_FULL_PD ||
      (!HAS_INT_REF && $past(new_mode) == adc_seq_pkg::MODE_FAST_PD))) else $error("full power-down decode wrong");
  chk_fast_pd: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // see [R16]
    cfg_evt |=> power_down_fast_q == (HAS_INT_REF && $past(new_mode) == adc_seq_pkg::MODE_FAST_PD))
    else $error("fast power-down decode wrong");
  chk_valid_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // see [R8]
    result_valid_q |=> !result_valid_q) else $error("result valid longer than one cycle");
endmodule // adc_serial_control_sequencer

// ---- pkg/adc_seq_pkg.sv ----
// Contract
// [R1] Single-ended: chosen input drives IN+, IN- goes to the common return.
// [R2] Differential: IN+/IN- come only from pairs 0/1, 2/3, 4/5, 6/7.
// [R3] Acquisition lasts three serial clocks, ending at the fall after bit eight.
// [R4] Tracking starts on the serial clock fall after the fifth control bit.
// [R5] Hold starts on the serial clock fall after the eighth control bit.
// [R6] Conversion starts by moving the hold capacitor from IN+ to IN-.
// [R7] At conversion end the hold capacitor goes back to IN+ and tracks; in internal mode the code tracks again only when read-out loads the result.
// [R8] Every result is a 10-bit value.
// [R9] Host sends a fresh control byte for each conversion.
// [R10] Byte all ones: single-ended unipolar input 7, external clock, no power-down.
// [R11] External clock: strobe high one serial period right before the MSB.
// [R12] Host gives 15 serial clocks per external-clock conversion; the code ignores input while converting and the test host gives 24.
// [R13] Strobe and serial output change only on serial clock falls; in internal mode the code moves the strobe on the reference clock.
// [R14] After chip select falls the first one is the start bit, bit 7.
// [R15] Bits 6..4 select one of eight analog inputs.
// [R16] Mode bits 1..0: 00 full down, 01 fast down, 10 internal, 11 external.
// [R17] Bit 3 one means unipolar; bit 2 one means single-ended.
// [R18] Zeros before the start bit are ignored.
// [R19] Conversion starts at the fall after bit eight, not at chip select.
// [R20] External clock: 12 decisions on the next 12 falls, MSB first; the code decides on the first 10 falls and sends zeros on the last 2.
// [R21] Input sampled on serial clock rise while selected; host uses mode 0.
// [R22] Control bits arrive MSB first.
package adc_seq_pkg;
  localparam int RESULT_W = 10;
  localparam logic [3:0] CTRL_BITS = 4'h8;
  localparam logic [3:0] TRACK_AFTER_BIT = 4'h5;
  localparam logic [3:0] LSB_STEP = 4'h9;
  localparam logic [3:0] LAST_STEP = 4'hB;
  localparam logic [9:0] SAR_MSB = 10'h200;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [1:0] MODE_FULL_PD = 2'h0;
  localparam logic [1:0] MODE_FAST_PD = 2'h1;
  localparam logic [1:0] MODE_INT = 2'h2;
  localparam logic [1:0] MODE_EXT = 2'h3;
  localparam int REF_PERIOD_PS = 4000;
  localparam int INT_STEP_NS = 600;
  localparam int INT_STEP_CYC = (INT_STEP_NS * 1000 + REF_PERIOD_PS - 1) / REF_PERIOD_PS;

  typedef struct packed {
    logic start_bit;
    logic channel_select_msb;
    logic channel_select_mid;
    logic channel_select_lsb;
    logic polarity_select;
    logic input_config_select;
    logic mode_bit_high;
    logic mode_bit_low;
  } ctrl_type;

  localparam ctrl_type CTRL_RESET = 8'h00;

  typedef struct packed {
    logic [7:0] pos_channel;
    logic [7:0] neg_channel;
    logic neg_to_common;
    logic hold_capacitor_to_neg;
    logic track_en;
  } route_type;

  typedef enum logic [1:0] {
    INT_IDLE = 2'b00,
    INT_CONV = 2'b01,
    INT_READY = 2'b11
  } int_state_type;
endpackage

// ---- hw/serial_link_engine.sv ----
`timescale 1ns/1ns
module serial_link_engine (
  input wire logic sclk,
  input wire logic link_rst_n,
  input wire logic sync_rst_n,
  input wire logic sdi,
  input wire logic comp_hi,
  input wire logic int_ready,
  input wire logic [9:0] int_result,
  output adc_seq_pkg::ctrl_type cfg_q,
  output logic [2:0] chan_q,
  output logic cfg_tgl_q,
  output logic done_tgl_q,
  output logic [9:0] res_q,
  output logic [9:0] trial_q,
  output logic converting_q,
  output logic tracking_q,
  output logic strobe_q,
  output logic dout_q
);
  logic [7:0] shift_q, shift_d;
  logic [3:0] bit_cnt_q, bit_cnt_d;
  adc_seq_pkg::ctrl_type cfg_d;
  logic [2:0] chan_d;
  logic cfg_tgl_d, done_tgl_d, converting_d, tracking_d, strobe_d, dout_d, loaded_q, loaded_d;
  logic [9:0] res_d, trial_d, sar_q, sar_d;
  logic [3:0] step_q, step_d;
  logic [11:0] rd_sh_q, rd_sh_d;
  logic rdy_meta_q, rdy_mid_q, rdy_late_q, ready_q;
  logic [7:0] ext_ones;

  // Rising edge: start-bit hunt and MSB-first shift; input is ignored while converting
  always_comb begin
    shift_d = shift_q;
    bit_cnt_d = bit_cnt_q;
    if (bit_cnt_q == adc_seq_pkg::CTRL_BITS || converting_q) begin
      bit_cnt_d = 4'h0;
    end else if (bit_cnt_q == 4'h0) begin
      if (sdi) begin // see [R14] [R18]
        shift_d = 8'h01;
        bit_cnt_d = 4'h1;
      end
    end else begin
      shift_d = {shift_q[6:0], sdi}; // see [R22]
      bit_cnt_d = bit_cnt_q + 4'h1;
    end
  end

  // Chip select high clears the whole frame state
  always_ff @(posedge sclk or negedge link_rst_n) begin // see [R21]
    if (!link_rst_n) begin
      shift_q <= 8'h00;
      bit_cnt_q <= 4'h0;
    end else begin
      shift_q <= shift_d;
      bit_cnt_q <= bit_cnt_d;
    end
  end

  // Falling edge: track/hold, conversion steps, strobe and data out
  always_comb begin
    cfg_d = cfg_q;
    chan_d = chan_q;
    cfg_tgl_d = cfg_tgl_q;
    done_tgl_d = done_tgl_q;
    res_d = res_q;
    trial_d = trial_q;
    sar_d = sar_q;
    step_d = step_q;
    converting_d = converting_q;
    tracking_d = tracking_q;
    strobe_d = 1'b0; // see [R11]
    dout_d = dout_q;
    loaded_d = loaded_q;
    rd_sh_d = rd_sh_q;
    if (bit_cnt_q == adc_seq_pkg::TRACK_AFTER_BIT) begin
      tracking_d = 1'b1; // see [R4]
      chan_d = shift_q[3:1]; // see [R15]
    end
    if (bit_cnt_q == adc_seq_pkg::CTRL_BITS) begin
      cfg_d = adc_seq_pkg::ctrl_type'(shift_q);
      cfg_tgl_d = ~cfg_tgl_q;
      tracking_d = 1'b0; // see [R5] [R3]
      loaded_d = 1'b0;
      if ({shift_q[1], shift_q[0]} == adc_seq_pkg::MODE_EXT) begin // see [R19] [R16] [R10]
        converting_d = 1'b1;
        strobe_d = 1'b1; // see [R11]
        step_d = 4'h0;
        sar_d = adc_seq_pkg::RESULT_RESET;
        trial_d = adc_seq_pkg::SAR_MSB;
      end
    end else if (converting_q) begin
      step_d = step_q + 4'h1;
      dout_d = 1'b0; // Sub-LSB positions carry no resolution here
      if (step_q <= adc_seq_pkg::LSB_STEP) begin
        sar_d = sar_q | (comp_hi ? (adc_seq_pkg::SAR_MSB >> step_q) : 10'h000);
        trial_d = sar_d | (adc_seq_pkg::SAR_MSB >> (step_q + 4'h1));
        dout_d = comp_hi; // see [R20] [R13]
      end
      if (step_q == adc_seq_pkg::LAST_STEP) begin
        converting_d = 1'b0;
        tracking_d = 1'b1; // see [R7]
        res_d = sar_q; // see [R8]
        done_tgl_d = ~done_tgl_q;
        trial_d = adc_seq_pkg::RESULT_RESET;
      end
    end else if ({cfg_q.mode_bit_high, cfg_q.mode_bit_low} == adc_seq_pkg::MODE_INT && ready_q && !loaded_q) begin
      rd_sh_d = {int_result, 2'b00};
      dout_d = int_result[9];
      loaded_d = 1'b1;
      tracking_d = 1'b1;
    end else if (loaded_q) begin
      rd_sh_d = {rd_sh_q[10:0], 1'b0};
      dout_d = rd_sh_q[10];
    end
  end

  // Frame state; chip select high clears it and aborts a running conversion
  always_ff @(negedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      trial_q <= adc_seq_pkg::RESULT_RESET;
      sar_q <= adc_seq_pkg::RESULT_RESET;
      step_q <= 4'h0;
      converting_q <= 1'b0;
      tracking_q <= 1'b0;
      strobe_q <= 1'b0;
      dout_q <= 1'b0;
      loaded_q <= 1'b0;
      rd_sh_q <= 12'h000;
    end else begin
      trial_q <= trial_d;
      sar_q <= sar_d;
      step_q <= step_d;
      converting_q <= converting_d;
      tracking_q <= tracking_d;
      strobe_q <= strobe_d;
      dout_q <= dout_d;
      loaded_q <= loaded_d;
      rd_sh_q <= rd_sh_d;
    end
  end

  // Byte, channel, result and toggles outlive chip select, so its rise never fakes an event on the reference side
  always_ff @(negedge sclk or negedge sync_rst_n) begin
    if (!sync_rst_n) begin
      cfg_q <= adc_seq_pkg::CTRL_RESET;
      chan_q <= 3'h0;
      cfg_tgl_q <= 1'b0;
      done_tgl_q <= 1'b0;
      res_q <= adc_seq_pkg::RESULT_RESET;
    end else begin
      cfg_q <= cfg_d;
      chan_q <= chan_d;
      cfg_tgl_q <= cfg_tgl_d;
      done_tgl_q <= done_tgl_d;
      res_q <= res_d;
    end
  end

  // Ready level from the reference domain; survives chip select so a result can be read later
  always_ff @(negedge sclk or negedge sync_rst_n) begin
    if (!sync_rst_n) begin
      rdy_meta_q <= 1'b0;
      rdy_mid_q <= 1'b0;
      rdy_late_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      rdy_meta_q <= int_ready;
      rdy_mid_q <= rdy_meta_q;
      rdy_late_q <= rdy_mid_q;
      ready_q <= (rdy_mid_q == rdy_late_q) ? rdy_late_q : ready_q;
    end
  end

  assign ext_ones = 8'hFF;

  chk_track_fifth: assert property (@(negedge sclk) disable iff (!link_rst_n) // see [R4]
    (bit_cnt_q == adc_seq_pkg::TRACK_AFTER_BIT) |=> tracking_q) else $error("no tracking after fifth bit");
  chk_hold_eighth: assert property (@(negedge sclk) disable iff (!link_rst_n) // see [R5]
    (bit_cnt_q == adc_seq_pkg::CTRL_BITS) |=> !tracking_q) else $error("no hold after eighth bit");
  chk_acq_three: assert property (@(negedge sclk) disable iff (!link_rst_n) // see [R3]
    (bit_cnt_q == adc_seq_pkg::TRACK_AFTER_BIT && !converting_q) |=> tracking_q[*3] ##1 !tracking_q)
    else $error("acquisition not three clocks");
  chk_ext_start: assert property (@(negedge sclk) disable iff (!link_rst_n) // see [R19]
    (bit_cnt_q == adc_seq_pkg::CTRL_BITS && shift_q[1:0] == adc_seq_pkg::MODE_EXT) |=> converting_q && strobe_q)
    else $error("conversion did not start after eighth bit");
  chk_strobe_single: assert property (@(negedge sclk) disable iff (!link_rst_n) // see [R11]
    $rose(strobe_q) |=> !strobe_q && converting_q && step_q == 4'h1) else $error("strobe not one period");
  chk_twelve_steps: assert property (@(negedge sclk) disable iff (!link_rst_n) // see [R20]
    $rose(converting_q) |-> ##11 converting_q ##1 !converting_q) else $error("not twelve decisions");
  chk_conv_hold: assert property (@(negedge sclk) disable iff (!link_rst_n) // see [R6]
    converting_q |-> !tracking_q) else $error("tracking during conversion");
  chk_release_track: assert property (@(negedge sclk) disable iff (!link_rst_n) // see [R7]
    $fell(converting_q) |-> tracking_q && res_q == $past(sar_q)) else $error("no re-track at end");
  chk_zero_ignore: assert property (@(posedge sclk) disable iff (!link_rst_n) // see [R18]
    (bit_cnt_q == 4'h0 && !sdi) |=> bit_cnt_q == 4'h0) else $error("zero taken as start");
  chk_all_ones: assert property (@(negedge sclk) disable iff (!link_rst_n) // see [R10]
    (bit_cnt_q == adc_seq_pkg::CTRL_BITS && shift_q == ext_ones) |=> chan_q == 3'h7 && converting_q)
    else $error("all-ones byte misread");
endmodule // serial_link_engine

// ---- sim/host_model.sv ----
`timescale 1ns/1ns
module host_model (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic dout_line,
  input wire logic strobe_line,
  input wire logic [1:0] watch
);
  // What was seen at each rising edge of a frame, index 0 = first rise
  logic [31:0] d_cap;
  logic [31:0] s_cap;
  logic [31:0] t_cap;
  logic [31:0] h_cap;

  // Clock idles low and stands still between frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    d_cap = '0;
    s_cap = '0;
    t_cap = '0;
    h_cap = '0;
  end

  // Mode 0 master: data set up while the clock is low, taken on the rise
  task automatic frame(input logic [31:0] bits, input int n);
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi = bits[31-i];
      #6;
      sclk = 1'b1;
      d_cap[i] = dout_line;
      s_cap[i] = strobe_line;
      t_cap[i] = watch[1];
      h_cap[i] = watch[0];
      #6;
      sclk = 1'b0;
    end
    #6;
    cs_n = 1'b1;
    sdi = 1'b0;
  endtask
endmodule // host_model

// ---- sim/tb.sv ----
`timescale 1ns/1ns
module tb;
  logic ref_clk;
  logic reset_n;
  logic [9:0] analog_q;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic comparator_high;
  logic dout_o;
  logic dout_oe_n;
  logic strobe_o;
  logic strobe_oe_n;
  logic [9:0] dac_code;
  adc_seq_pkg::route_type route;
  logic [9:0] result_data_q;
  logic result_valid_q;
  logic result_unipolar_q;
  logic power_down_full_q;
  logic power_down_fast_q;
  logic [9:0] last_res;
  int failures = 0;
  int n_compared = 0;
  int n_valid = 0;

  // Half-LSB offset so a trial code never equals the input exactly
  assign comparator_high = ({analog_q, 1'b1} > {dac_code, 1'b0});

  adc_serial_control_sequencer #(.STEP_CYC(4)) adc_serial_control_sequencer_i (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .sclk(sclk),
    .cs_n(cs_n),
    .sdi(sdi),
    .comparator_high(comparator_high),
    .dout_o(dout_o),
    .dout_oe_n(dout_oe_n),
    .strobe_o(strobe_o),
    .strobe_oe_n(strobe_oe_n),
    .dac_code(dac_code),
    .route(route),
    .result_data_q(result_data_q),
    .result_valid_q(result_valid_q),
    .result_unipolar_q(result_unipolar_q),
    .power_down_full_q(power_down_full_q),
    .power_down_fast_q(power_down_fast_q)
  );

  // A released pin shows the inverse so a stale value cannot pass
  host_model host_model_i (
    .sclk(sclk),
    .cs_n(cs_n),
    .sdi(sdi),
    .dout_line(dout_oe_n ? ~dout_o : dout_o),
    .strobe_line(strobe_oe_n ? ~strobe_o : strobe_o),
    .watch({route.track_en, route.hold_capacitor_to_neg})
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Result capture on the reference side
  always @(posedge ref_clk) begin
    if (result_valid_q === 1'b1) begin
      n_valid <= n_valid + 1;
      last_res <= result_data_q;
    end
  end

  // Serial outputs may only move while the serial clock is low
  always @(dout_o or strobe_o) begin
    if (cs_n === 1'b0 && sclk === 1'b1) begin
      failures++;
      $display("Error serial_edge expected fall seen rise");
    end
  end

  task automatic report_and_stop();
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_ref(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic route_check(input logic [7:0] ctrl);
    logic [2:0] idx;
    idx = {ctrl[5], ctrl[4], ctrl[6]};
    check("pos", 8'h01 << idx, route.pos_channel);
    check("neg", ctrl[2] ? 8'h00 : 8'h01 << (idx ^ 3'h1), route.neg_channel);
    check("to_common", ctrl[2], route.neg_to_common);
    check("full_pd", ctrl[1:0] == 2'h0, power_down_full_q);
    check("fast_pd", ctrl[1:0] == 2'h1, power_down_fast_q);
  endtask

  // Control byte then 16 padding clocks; k leading zeros shift everything
  task automatic ext_frame(input logic [7:0] ctrl, input int k, input logic [9:0] a, input logic uni);
    logic [31:0] es, ed, et, eh, m, md;
    int v0;
    es = '0;
    ed = '0;
    et = '0;
    eh = '0;
    m = '0;
    md = '0;
    @(posedge ref_clk);
    analog_q <= a;
    v0 = n_valid;
    host_model_i.frame({ctrl, 24'h0} >> k, 24 + k);
    for (int j = 0; j < 22; j++) begin
      m[k+j] = 1'b1;
      es[k+j] = (j == 8);
      et[k+j] = (j >= 5 && j <= 7) || j >= 20;
      eh[k+j] = (j >= 8 && j <= 19);
      md[k+j] = (j >= 9 && j <= 20);
      ed[k+j] = (j >= 9 && j <= 18) ? a[18-j] : 1'b0;
    end
    wait_ref(12);
    check("strobe", es, host_model_i.s_cap & m);
    if (uni) check("dout", ed, host_model_i.d_cap & md);
    check("track", et, host_model_i.t_cap & m);
    check("hold_to_neg", eh, host_model_i.h_cap & m);
    check("results", v0 + 1, n_valid);
    check("unipolar", uni, result_unipolar_q);
    if (uni) check("result", a, last_res);
    check("dout_oe_n", 1, dout_oe_n);
    route_check(ctrl);
  endtask

  task automatic route_test(input logic [7:0] ctrl);
    host_model_i.frame({ctrl, 24'h0}, 8);
    wait_ref(12);
    route_check(ctrl);
  endtask

  // Internal conversion: host stops clocking and waits for the result
  task automatic int_test(input logic [9:0] a);
    int v0;
    @(posedge ref_clk);
    analog_q <= a;
    v0 = n_valid;
    host_model_i.frame({8'hAE, 24'h0}, 8);
    for (int t = 0; t < 1000 && n_valid == v0; t++) wait_ref(1);
    if (n_valid == v0) begin
      failures++;
      $display("Error int_done expected pulse seen none");
      report_and_stop();
    end
    check("int_result", a, last_res);
    check("int_strobe_oe_n", 0, strobe_oe_n);
    check("int_strobe", 1, strobe_o);
    // Read-out frame: ready crosses in four serial falls, the fifth fall shows the MSB
    host_model_i.frame(32'h0, 16);
    for (int j = 0; j < 10; j++) check("int_dout", a[9-j], host_model_i.d_cap[5+j]);
    wait_ref(4);
    route_check(8'hAE);
  endtask

  initial begin
    reset_n = 1'b0;
    analog_q = 10'h000;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    wait_ref(4);
    ext_frame(8'hFF, 0, 10'h2A5, 1'b1);
    ext_frame(8'hBF, 3, 10'h15A, 1'b1);
    ext_frame(8'h87, 0, 10'h3C3, 1'b0);
    for (int c = 0; c < 16; c++) route_test({1'b1, c[2:0], 1'b1, c[3], 2'h0});
    route_test(8'hF5);
    int_test(10'h1E7);
    report_and_stop();
  end
endmodule // tb
